// ==== pkg/pam_pkg.sv ====
// constants, layouts and types of the protection alarm monitor
// assumes one system clock; frames arrive as bytes from the link logic
package pam_pkg;
	localparam logic [31:0] CMD_CODE = 32'h63657373;
	localparam int FRAME_LEN = 28;
	localparam logic [4:0] LAST_IDX = 5'h1b;
	localparam logic [1:0] TX_LAST = 2'h3;
	localparam int OFF_CUT = 4;
	localparam int OFF_MI = 6;
	localparam int OFF_MV = 8;
	localparam int OFF_TEMP = 10;
	localparam int OFF_LI = 12;
	localparam int OFF_LVH = 14;
	localparam int OFF_LVL = 16;
	localparam int OFF_FLAGS = 18;
	localparam int OFF_CRC = 26;
	localparam logic [4:0] SUM_FIRST = 5'h04;
	localparam logic [4:0] SUM_LAST = 5'h19;
	// flag byte bit positions
	localparam int F_HEAT = 0;
	localparam int F_UV = 1;
	localparam int F_BRIDGE = 2;
	localparam int F_SWAP = 3;
	localparam int F_LATCH = 4;
	localparam int F_RECON = 5;
	// alarm source bit positions
	localparam int A_MI = 0;
	localparam int A_MV = 1;
	localparam int A_TEMP = 2;
	localparam int A_LI = 3;
	localparam int A_LVH = 4;
	localparam int A_LVL = 5;
	localparam int A_HEAT = 6;
	localparam int A_SWAP = 7;
	// register map, byte addresses
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_ALARM = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0c;
	localparam logic [7:0] REG_FLAGS = 8'h10;
	localparam int S_APPLIED = 0;
	localparam int S_BADFRM = 1;
	localparam int S_ALARM = 2;
	localparam int S_CUTOFF = 3;
	localparam int C_STOP = 0;
	localparam int R_MOFF = 8;
	localparam int R_POFF = 9;
	localparam int R_CFG = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [15:0] motor_supply_cutoff_level;
		logic [15:0] motor_current_limit;
		logic [15:0] motor_voltage_limit;
		logic [15:0] temperature_limit;
		logic [15:0] link_current_limit;
		logic [15:0] link_voltage_high_limit;
		logic [15:0] link_voltage_low_limit;
		logic [7:0] flags;
	} pam_cfg_s;
	typedef struct packed {
		logic [15:0] motor_v;
		logic [15:0] motor_i;
		logic [15:0] temp;
		logic [15:0] link_i;
		logic [15:0] link_v;
		logic drv_heat;
		logic limit_swap;
		logic bridge_fault;
	} pam_meas_s;
	typedef enum logic [2:0] {
		ST_RX = 3'b001,
		ST_CHK = 3'b010,
		ST_TX = 3'b100
	} pam_st_e;
endpackage

// ==== design/pam_monitor.sv ====
// protection alarm monitor: settings frame receiver, limit checks, regs
// assumes byte stream and AXI4-Lite on MCLK; measurements are asynchronous
// Summary of operation
// - frame is 28 bytes with fixed code
// - undervoltage enabled: motor off below cutoff
// - alarm when motor current over limit
// - alarm when motor voltage over limit
// - alarm when temperature over limit
// - alarm when link current over limit
// - alarm when link voltage above upper limit
// - alarm when link voltage below lower limit
// - flags enable overheat and border-swap alarms
// - bridge fault cuts power stage when enabled
// - latched alarms cleared only by stop
// - flag enables link reconnect recovery
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module pam_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_LAST,
	output logic RX_READY,
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY,
	input wire logic [15:0] MOTOR_V,
	input wire logic [15:0] MOTOR_I,
	input wire logic [15:0] TEMP,
	input wire logic [15:0] LINK_I,
	input wire logic [15:0] LINK_V,
	input wire logic DRV_HEAT,
	input wire logic LIMIT_SWAP,
	input wire logic BRIDGE_FAULT,
	input wire logic STOP_CMD,
	output logic ALARM,
	output logic MOTOR_OFF,
	output logic POWER_OFF,
	output logic RECONNECT_EN,
	output logic IRQ,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	pam_pkg::pam_meas_s meas_m_r, meas_s_r, meas_in;
	pam_pkg::pam_cfg_s cfg_r, cfg_nxt;
	pam_pkg::pam_st_e st_r, st_nxt;
	logic [7:0] buf_r [pam_pkg::FRAME_LEN];
	logic [7:0] buf_nxt [pam_pkg::FRAME_LEN];
	logic [4:0] cnt_r, cnt_nxt;
	logic [15:0] sum_r, sum_nxt;
	logic over_r, over_nxt, cfg_ok_r, cfg_ok_nxt;
	logic [1:0] tx_idx_r, tx_idx_nxt;
	logic rx_ready_nxt, tx_valid_nxt;
	logic [7:0] tx_data_nxt;
	logic rx_hs, ev_applied, ev_bad, frame_ok;
	logic [7:0] src_now, src_r, src_nxt;
	logic alarm_r, alarm_nxt, moff_r, moff_nxt, poff_r, poff_nxt;
	logic recon_r, recon_nxt, stop_any;
	logic [3:0] status_r, status_nxt, mask_r, mask_nxt, w1c, ev;
	logic irq_r, irq_nxt, sw_stop;
	logic aw_hs, w_hs, ar_hs, do_wr;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, wmask;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

	assign meas_in = '{MOTOR_V, MOTOR_I, TEMP, LINK_I, LINK_V, DRV_HEAT,
		LIMIT_SWAP, BRIDGE_FAULT};

	// two-stage synchroniser; analog words change slowly, so a torn
	// sample is tolerated for one cycle rather than paying a handshake
	always_ff @(posedge MCLK) begin
		if (RST) begin
			meas_m_r <= '0;
			meas_s_r <= '0;
		end else begin
			meas_m_r <= meas_in;
			meas_s_r <= meas_m_r;
		end
	end

	// frame receiver, checker and answer
	always_comb begin
		st_nxt = st_r;
		buf_nxt = buf_r;
		cnt_nxt = cnt_r;
		sum_nxt = sum_r;
		over_nxt = over_r;
		cfg_nxt = cfg_r;
		cfg_ok_nxt = cfg_ok_r;
		tx_idx_nxt = tx_idx_r;
		tx_valid_nxt = TX_VALID;
		tx_data_nxt = TX_DATA;
		ev_applied = 1'b0;
		ev_bad = 1'b0;
		rx_hs = RX_VALID & RX_READY;
		frame_ok = ({buf_r[3], buf_r[2], buf_r[1], buf_r[0]} ==
			pam_pkg::CMD_CODE) &&
			({buf_r[pam_pkg::OFF_CRC + 1], buf_r[pam_pkg::OFF_CRC]} == sum_r);
		unique case (st_r)
			pam_pkg::ST_RX: begin
				if (rx_hs) begin
					if (!over_r)
						buf_nxt[cnt_r] = RX_DATA;
					if (cnt_r >= pam_pkg::SUM_FIRST && cnt_r <= pam_pkg::SUM_LAST &&
						!over_r)
						sum_nxt = sum_r + {8'h00, RX_DATA};
					if (RX_LAST) begin
						cnt_nxt = '0;
						over_nxt = 1'b0;
						if (cnt_r == pam_pkg::LAST_IDX && !over_r) begin
							st_nxt = pam_pkg::ST_CHK;
						end else begin
							ev_bad = 1'b1;
							sum_nxt = '0;
						end
					end else if (cnt_r == pam_pkg::LAST_IDX) begin
						over_nxt = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
			pam_pkg::ST_CHK: begin
				sum_nxt = '0;
				if (frame_ok) begin
					cfg_nxt.motor_supply_cutoff_level =
						{buf_r[pam_pkg::OFF_CUT + 1], buf_r[pam_pkg::OFF_CUT]};
					cfg_nxt.motor_current_limit =
						{buf_r[pam_pkg::OFF_MI + 1], buf_r[pam_pkg::OFF_MI]};
					cfg_nxt.motor_voltage_limit =
						{buf_r[pam_pkg::OFF_MV + 1], buf_r[pam_pkg::OFF_MV]};
					cfg_nxt.temperature_limit =
						{buf_r[pam_pkg::OFF_TEMP + 1], buf_r[pam_pkg::OFF_TEMP]};
					cfg_nxt.link_current_limit =
						{buf_r[pam_pkg::OFF_LI + 1], buf_r[pam_pkg::OFF_LI]};
					cfg_nxt.link_voltage_high_limit =
						{buf_r[pam_pkg::OFF_LVH + 1], buf_r[pam_pkg::OFF_LVH]};
					cfg_nxt.link_voltage_low_limit =
						{buf_r[pam_pkg::OFF_LVL + 1], buf_r[pam_pkg::OFF_LVL]};
					cfg_nxt.flags = buf_r[pam_pkg::OFF_FLAGS];
					cfg_ok_nxt = 1'b1;
					ev_applied = 1'b1;
					st_nxt = pam_pkg::ST_TX;
					tx_idx_nxt = '0;
					tx_valid_nxt = 1'b1;
					tx_data_nxt = pam_pkg::CMD_CODE[7:0];
				end else begin
					ev_bad = 1'b1;
					st_nxt = pam_pkg::ST_RX;
				end
			end
			pam_pkg::ST_TX: begin
				if (TX_READY) begin
					if (tx_idx_r == pam_pkg::TX_LAST) begin
						tx_valid_nxt = 1'b0;
						st_nxt = pam_pkg::ST_RX;
					end else begin
						tx_idx_nxt = tx_idx_r + 2'h1;
						tx_data_nxt = pam_pkg::CMD_CODE[{tx_idx_nxt, 3'h0} +: 8];
					end
				end
			end
			default: st_nxt = pam_pkg::ST_RX;
		endcase
		rx_ready_nxt = (st_nxt == pam_pkg::ST_RX);
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			st_r <= pam_pkg::ST_RX;
			buf_r <= '{default: 8'h00};
			cnt_r <= '0;
			sum_r <= '0;
			over_r <= 1'b0;
			cfg_r <= '0;
			cfg_ok_r <= 1'b0;
			tx_idx_r <= '0;
			RX_READY <= 1'b0;
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
		end else begin
			st_r <= st_nxt;
			buf_r <= buf_nxt;
			cnt_r <= cnt_nxt;
			sum_r <= sum_nxt;
			over_r <= over_nxt;
			cfg_r <= cfg_nxt;
			cfg_ok_r <= cfg_ok_nxt;
			tx_idx_r <= tx_idx_nxt;
			RX_READY <= rx_ready_nxt;
			TX_VALID <= tx_valid_nxt;
			TX_DATA <= tx_data_nxt;
		end
	end

	// limit checks; nothing trips before the first valid settings frame
	always_comb begin
		stop_any = STOP_CMD | sw_stop;
		src_now = '0;
		src_now[pam_pkg::A_MI] = meas_s_r.motor_i > cfg_r.motor_current_limit;
		src_now[pam_pkg::A_MV] = meas_s_r.motor_v > cfg_r.motor_voltage_limit;
		src_now[pam_pkg::A_TEMP] = meas_s_r.temp > cfg_r.temperature_limit;
		src_now[pam_pkg::A_LI] = meas_s_r.link_i > cfg_r.link_current_limit;
		src_now[pam_pkg::A_LVH] = meas_s_r.link_v > cfg_r.link_voltage_high_limit;
		src_now[pam_pkg::A_LVL] = meas_s_r.link_v < cfg_r.link_voltage_low_limit;
		src_now[pam_pkg::A_HEAT] = meas_s_r.drv_heat & cfg_r.flags[pam_pkg::F_HEAT];
		src_now[pam_pkg::A_SWAP] = meas_s_r.limit_swap &
			cfg_r.flags[pam_pkg::F_SWAP];
		src_now = src_now & {8{cfg_ok_r}};
		// sticky until stop; stop zeroes, a live fault re-arms next cycle
		if (cfg_r.flags[pam_pkg::F_LATCH])
			src_nxt = stop_any ? 8'h00 : (src_r | src_now);
		else
			src_nxt = src_now;
		alarm_nxt = |src_nxt;
		moff_nxt = cfg_ok_r & cfg_r.flags[pam_pkg::F_UV] &
			(meas_s_r.motor_v < cfg_r.motor_supply_cutoff_level);
		poff_nxt = cfg_ok_r & cfg_r.flags[pam_pkg::F_BRIDGE] &
			meas_s_r.bridge_fault;
		recon_nxt = cfg_r.flags[pam_pkg::F_RECON];
		ev = '0;
		ev[pam_pkg::S_APPLIED] = ev_applied;
		ev[pam_pkg::S_BADFRM] = ev_bad;
		ev[pam_pkg::S_ALARM] = alarm_nxt & ~alarm_r;
		ev[pam_pkg::S_CUTOFF] = moff_nxt & ~moff_r;
		// set wins over a simultaneous write-one-to-clear
		status_nxt = (status_r & ~w1c) | ev;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			src_r <= '0;
			alarm_r <= 1'b0;
			moff_r <= 1'b0;
			poff_r <= 1'b0;
			recon_r <= 1'b0;
			status_r <= '0;
			irq_r <= 1'b0;
		end else begin
			src_r <= src_nxt;
			alarm_r <= alarm_nxt;
			moff_r <= moff_nxt;
			poff_r <= poff_nxt;
			recon_r <= recon_nxt;
			status_r <= status_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign ALARM = alarm_r;
	assign MOTOR_OFF = moff_r;
	assign POWER_OFF = poff_r;
	assign RECONNECT_EN = recon_r;
	assign IRQ = irq_r;

	// AXI4-Lite slave; address and data accepted in either order
	always_comb begin
		aw_hs = S_AXI_AWVALID & awready_r;
		w_hs = S_AXI_WVALID & wready_r;
		ar_hs = S_AXI_ARVALID & arready_r;
		aw_got_nxt = aw_got_r | aw_hs;
		w_got_nxt = w_got_r | w_hs;
		waddr_nxt = aw_hs ? S_AXI_AWADDR : waddr_r;
		wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
			{8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
		wdata_nxt = w_hs ? (S_AXI_WDATA & wmask) : wdata_r;
		bvalid_nxt = bvalid_r & ~S_AXI_BREADY;
		bresp_nxt = bresp_r;
		mask_nxt = mask_r;
		w1c = '0;
		sw_stop = 1'b0;
		do_wr = aw_got_nxt & w_got_nxt & ~bvalid_nxt;
		if (do_wr) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = pam_pkg::RESP_OKAY;
			unique case (waddr_nxt)
				pam_pkg::REG_STATUS: w1c = wdata_nxt[3:0];
				pam_pkg::REG_MASK: mask_nxt = wdata_nxt[3:0];
				pam_pkg::REG_CTRL: sw_stop = wdata_nxt[pam_pkg::C_STOP];
				pam_pkg::REG_ALARM, pam_pkg::REG_FLAGS: ;
				default: bresp_nxt = pam_pkg::RESP_SLVERR;
			endcase
		end
		awready_nxt = ~aw_got_nxt;
		wready_nxt = ~w_got_nxt;
		rvalid_nxt = rvalid_r & ~S_AXI_RREADY;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (ar_hs) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = pam_pkg::RESP_OKAY;
			rdata_nxt = '0;
			unique case (S_AXI_ARADDR)
				pam_pkg::REG_STATUS: rdata_nxt[3:0] = status_r;
				pam_pkg::REG_MASK: rdata_nxt[3:0] = mask_r;
				pam_pkg::REG_ALARM: begin
					rdata_nxt[7:0] = src_r;
					rdata_nxt[pam_pkg::R_MOFF] = moff_r;
					rdata_nxt[pam_pkg::R_POFF] = poff_r;
					rdata_nxt[pam_pkg::R_CFG] = cfg_ok_r;
				end
				pam_pkg::REG_CTRL: ;
				pam_pkg::REG_FLAGS: rdata_nxt[7:0] = cfg_r.flags;
				default: rresp_nxt = pam_pkg::RESP_SLVERR;
			endcase
		end
		arready_nxt = ~rvalid_nxt;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			arready_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= pam_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= pam_pkg::RESP_OKAY;
			mask_r <= '0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			mask_r <= mask_nxt;
		end
	end

	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_good_check;
		st_r == pam_pkg::ST_CHK && frame_ok;
	endsequence
	sequence s_echo;
		TX_VALID && TX_DATA == pam_pkg::CMD_CODE[7:0];
	endsequence

	property p_frame_len;
		st_r == pam_pkg::ST_CHK |-> $past(RX_LAST && rx_hs &&
			cnt_r == pam_pkg::LAST_IDX && !over_r);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad length");
	property p_cutoff;
		cfg_ok_r && cfg_r.flags[pam_pkg::F_UV] &&
			meas_s_r.motor_v < cfg_r.motor_supply_cutoff_level |=> MOTOR_OFF;
	endproperty
	a_cutoff: assert property (p_cutoff) else $error("no cutoff");
	// a stop zeroes latched sources for one edge, even a live fault
	property p_mot_i;
		cfg_ok_r && !stop_any &&
			meas_s_r.motor_i > cfg_r.motor_current_limit |=>
			ALARM && src_r[pam_pkg::A_MI];
	endproperty
	a_mot_i: assert property (p_mot_i) else $error("no current alarm");
	property p_temp;
		cfg_ok_r && !stop_any &&
			meas_s_r.temp > cfg_r.temperature_limit |=>
			src_r[pam_pkg::A_TEMP];
	endproperty
	a_temp: assert property (p_temp) else $error("no temp alarm");
	property p_link_low;
		cfg_ok_r && !stop_any &&
			meas_s_r.link_v < cfg_r.link_voltage_low_limit |=>
			src_r[pam_pkg::A_LVL];
	endproperty
	a_link_low: assert property (p_link_low) else $error("no low alarm");
	property p_bridge;
		POWER_OFF |-> $past(cfg_r.flags[pam_pkg::F_BRIDGE] &&
			meas_s_r.bridge_fault);
	endproperty
	a_bridge: assert property (p_bridge) else $error("bad power cut");
	property p_latch;
		ALARM && cfg_r.flags[pam_pkg::F_LATCH] && !stop_any |=> ALARM;
	endproperty
	a_latch: assert property (p_latch) else $error("alarm dropped");
	property p_recon;
		##1 RECONNECT_EN == $past(cfg_r.flags[pam_pkg::F_RECON]);
	endproperty
	a_recon: assert property (p_recon) else $error("reconnect wrong");
	property p_echo;
		s_good_check |=> s_echo;
	endproperty
	a_echo: assert property (p_echo) else $error("no echo");
	property p_keep;
		st_r == pam_pkg::ST_CHK && !frame_ok |=> $stable(cfg_r);
	endproperty
	a_keep: assert property (p_keep) else $error("settings changed");
endmodule

// ==== sim/pam_host.sv ====
// host model of the byte command link: sends frames, takes answers
// assumes the monitor samples on rising mclk and answers lsb first
`timescale 1ns/1ps
module pam_host (
	input wire logic mclk,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic tx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end
	task automatic xfer(input logic [7:0] q[$], input bit slow,
		output logic [31:0] ans, output int n);
		int i;
		int k;
		bit bad;
		n = 0;
		bad = 1'b0;
		ans = 32'h0;
		@(posedge mclk);
		for (i = 0; i < q.size(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= q[i];
			rx_last <= (i == q.size() - 1);
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (!rx_ready && k < 50);
			if (k >= 50) bad = 1'b1;
		end
		// released line shows the inverse, never a stale byte
		rx_valid <= 1'b0;
		rx_data <= ~q[q.size() - 1];
		rx_last <= 1'b0;
		// slow host stalls every other cycle
		for (k = 0; k < 40 && n < 4; k++) begin
			tx_ready <= slow ? k[0] : 1'b1;
			@(posedge mclk);
			if (tx_valid && tx_ready) begin
				ans[n * 8 +: 8] = tx_data;
				n++;
			end
		end
		tx_ready <= 1'b0;
		// a stalled byte spoils the count so the bench flags it
		if (bad) n = -1;
	endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench of the protection alarm monitor
// assumes the host model on the byte link; bench drives axi4-lite
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data, awaddr, araddr, flg;
	logic [15:0] motor_v, motor_i, temp, link_i, link_v;
	logic drv_heat, limit_swap, bridge_fault, stop_cmd;
	logic alarm, motor_off, power_off, reconnect_en, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] fr[$];
	int fail_count, checks_done;
	int lim[7];
	pam_monitor i_pam_monitor (.MCLK(mclk), .RST(rst),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last),
		.RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
		.TX_READY(tx_ready), .MOTOR_V(motor_v), .MOTOR_I(motor_i),
		.TEMP(temp), .LINK_I(link_i), .LINK_V(link_v),
		.DRV_HEAT(drv_heat), .LIMIT_SWAP(limit_swap),
		.BRIDGE_FAULT(bridge_fault), .STOP_CMD(stop_cmd), .ALARM(alarm),
		.MOTOR_OFF(motor_off), .POWER_OFF(power_off),
		.RECONNECT_EN(reconnect_en), .IRQ(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	pam_host i_pam_host (.mclk(mclk), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic results();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask
	task automatic chk_pins(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: pins %b/%b", $time, got, exp);
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 50) begin
			fail_count++;
			$display("wrong value at %0t: no handshake", $time);
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && k < 50);
		tmo(k);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && k < 50);
		tmo(k);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e, m);
		chk(r, pam_pkg::RESP_OKAY, "rresp");
	endtask
	// kind 0 good, 1 wrong code, 2 bad checksum, 3 short, 4 long
	task automatic send(input int kind, input bit slow, output int n);
		logic [31:0] code, ans;
		int i, s;
		code = (kind == 1) ? 32'h73736563 : pam_pkg::CMD_CODE;
		fr = {};
		for (i = 0; i < 4; i++) fr.push_back(code[i * 8 +: 8]);
		for (i = 0; i < 7; i++) begin
			fr.push_back(8'(lim[i]));
			fr.push_back(8'(lim[i] >> 8));
		end
		fr.push_back(flg);
		for (i = 0; i < 7; i++) fr.push_back(8'($urandom));
		s = 0;
		for (i = 4; i < 26; i++) s += fr[i];
		s += (kind == 2);
		fr.push_back(8'(s));
		fr.push_back(8'(s >> 8));
		if (kind == 3) void'(fr.pop_back());
		if (kind == 4) fr.push_back(8'h00);
		i_pam_host.xfer(fr, slow, ans, n);
		if (kind == 0) chk(ans, pam_pkg::CMD_CODE, "answer");
	endtask
	function automatic logic [10:0] model();
		logic [10:0] e;
		e[0] = motor_i > lim[1];
		e[1] = motor_v > lim[2];
		e[2] = temp > lim[3];
		e[3] = link_i > lim[4];
		e[4] = link_v > lim[5];
		e[5] = link_v < lim[6];
		e[6] = drv_heat & flg[0];
		e[7] = limit_swap & flg[3];
		e[8] = flg[1] & (motor_v < lim[0]);
		e[9] = flg[2] & bridge_fault;
		e[10] = 1'b1;
		return e;
	endfunction
	// values within one count of the limits hit the strict boundary
	task automatic meas();
		logic [10:0] e;
		@(posedge mclk);
		motor_i <= 16'(lim[1] + $urandom % 3 - 1);
		motor_v <= 16'(lim[$urandom % 2 * 2] + $urandom % 3 - 1);
		temp <= 16'(lim[3] + $urandom % 3 - 1);
		link_i <= 16'(lim[4] + $urandom % 3 - 1);
		link_v <= 16'(lim[5 + $urandom % 2] + $urandom % 3 - 1);
		{drv_heat, limit_swap, bridge_fault} <= 3'($urandom);
		repeat (5) @(posedge mclk);
		e = model();
		rchk(pam_pkg::REG_ALARM, {21'h0, e}, "alarm");
		chk_pins({alarm, motor_off, power_off, reconnect_en},
			{|e[7:0], e[8], e[9], flg[5]});
	endtask
	// stale sources from earlier settings stay latched until a stop
	task automatic safe();
		@(posedge mclk);
		{motor_v, motor_i, temp, link_i} <= 64'h0;
		link_v <= 16'd1000;
		{drv_heat, limit_swap, bridge_fault} <= 3'b0;
		repeat (5) @(posedge mclk);
		stop_cmd <= 1'b1;
		@(posedge mclk);
		stop_cmd <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n, c, j;
		{rst, stop_cmd, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{awaddr, araddr, wdata, wstrb} = 52'hf;
		{motor_v, motor_i, temp, link_i, link_v} = 80'h0;
		{drv_heat, limit_swap, bridge_fault} = 3'b0;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(32'hc2c7f516));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		for (j = 0; j < 5; j++) rchk(8'(j * 4), 32'h0, "reset value");
		for (c = 0; c < 3; c++) begin
			for (j = 0; j < 7; j++) lim[j] = 100 + $urandom % 60000;
			flg = (c == 0) ? 8'h2f : (c == 1) ? 8'($urandom) & 8'h2f : 8'h0;
			send(0, c[0], n);
			chk(n, 4, "answer bytes");
			rchk(pam_pkg::REG_FLAGS, {24'h0, flg}, "flags");
			rd(pam_pkg::REG_STATUS, d, r);
			chk(d[pam_pkg::S_APPLIED], 1'b1, "applied");
			for (j = 0; j < 8; j++) meas();
		end
		for (j = 1; j < 5; j++) begin
			wr(pam_pkg::REG_STATUS, 32'hf, r);
			flg ^= 8'h20;
			lim[1] ^= 1;
			send(j, 1'b0, n);
			flg ^= 8'h20;
			lim[1] ^= 1;
			chk(n, 0, "refused frame answered");
			rchk(pam_pkg::REG_FLAGS, {24'h0, flg}, "flags kept");
			rd(pam_pkg::REG_STATUS, d, r);
			chk(d[1], 1'b1, "bad frame status");
			meas();
		end
		flg = 8'h10;
		for (j = 0; j < 7; j++) lim[j] = 1000;
		send(0, 1'b0, n);
		for (c = 0; c < 2; c++) begin
			safe();
			@(posedge mclk);
			motor_i <= 16'd1001;
			repeat (5) @(posedge mclk);
			motor_i <= 16'd0;
			repeat (5) @(posedge mclk);
			rchk(pam_pkg::REG_ALARM, 32'h401, "latched");
			if (c == 0) begin
				stop_cmd <= 1'b1;
				@(posedge mclk);
				stop_cmd <= 1'b0;
			end else begin
				wr(pam_pkg::REG_CTRL, 32'h1, r);
			end
			repeat (5) @(posedge mclk);
			rchk(pam_pkg::REG_ALARM, 32'h400, "stop clears");
		end
		wr(pam_pkg::REG_STATUS, 32'hf, r);
		rchk(pam_pkg::REG_STATUS, 32'h0, "status cleared");
		wr(pam_pkg::REG_MASK, 32'h4, r);
		rchk(pam_pkg::REG_MASK, 32'h4, "mask");
		@(posedge mclk);
		motor_i <= 16'd1001;
		repeat (5) @(posedge mclk);
		chk(irq, 1'b1, "irq raised");
		wr(pam_pkg::REG_MASK, 32'h0, r);
		chk(irq, 1'b0, "irq masked");
		wr(pam_pkg::REG_MASK, 32'h4, r);
		chk(irq, 1'b1, "irq unmasked");
		wr(pam_pkg::REG_STATUS, 32'h4, r);
		chk(irq, 1'b0, "irq cleared");
		wstrb <= 4'he;
		wr(pam_pkg::REG_MASK, 32'h5, r);
		rchk(pam_pkg::REG_MASK, 32'h0, "strobe lane zeroed");
		wstrb <= 4'hf;
		wr(pam_pkg::REG_FLAGS, 32'hff, r);
		rchk(pam_pkg::REG_FLAGS, 32'h10, "flags read only");
		rd(8'h40, d, r);
		chk(d, 32'h0, "unmapped read data");
		chk({30'h0, r}, {30'h0, pam_pkg::RESP_SLVERR}, "unmapped read");
		wr(8'h44, 32'h1, r);
		chk(r, pam_pkg::RESP_SLVERR, "unmapped write");
		results();
	end
endmodule
